// file: hw/adc_ctrl_pkg.sv
// package: register map, field positions, reset values and timing of the converter control
package adc_ctrl_pkg;
	localparam int         ADDR_W       = 4;
	localparam logic [3:0] OFS_CHAN     = 4'h0;
	localparam logic [3:0] OFS_TRIG     = 4'h1;
	localparam logic [3:0] OFS_RES_HI   = 4'h2;
	localparam logic [3:0] OFS_RES_LO   = 4'h3;
	localparam logic [3:0] OFS_CFG      = 4'h4;
	localparam logic [3:0] OFS_CMP_HI   = 4'h5;
	localparam logic [3:0] OFS_CMP_LO   = 4'h6;
	localparam logic [3:0] OFS_PIN_A    = 4'h7;
	localparam logic [3:0] OFS_PIN_B    = 4'h8;
	localparam int         CFG_LOWPWR   = 7;
	localparam int         CFG_DIV_LO   = 5;
	localparam int         CFG_LSMP     = 4;
	localparam int         CFG_MODE_LO  = 2;
	localparam int         CFG_CLK_LO   = 0;
	localparam int         TRG_SRC      = 6;
	localparam int         TRG_CMP_EN   = 5;
	localparam int         TRG_CMP_GT   = 4;
	localparam logic [7:0] TRG_WMASK    = 8'h70;
	localparam int         CIC_IEN      = 6;
	localparam int         CIC_CONT     = 5;
	localparam logic [7:0] CIC_WMASK    = 8'h7F;
	localparam logic [1:0] MODE_10BIT   = 2'h2;
	localparam logic [1:0] CLK_BUS      = 2'h0;
	localparam logic [1:0] CLK_BUS_HALF = 2'h1;
	localparam logic [1:0] CLK_ALT      = 2'h2;
	localparam logic [1:0] CLK_ASYNC    = 2'h3;
	localparam logic [1:0] DIV_ONE      = 2'h0;
	localparam logic [3:0] MSB_10BIT    = 4'h9;
	localparam logic [3:0] MSB_8BIT     = 4'h7;
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam logic [9:0] RST_WORD     = 10'h000;
	localparam int         SAMPLE_SHORT_X10  = 35;
	localparam int         SAMPLE_LONG_X10   = 235;
	localparam int         SAMPLE_SHORT_CYC  = (SAMPLE_SHORT_X10 + 9) / 10;
	localparam int         SAMPLE_LONG_CYC   = (SAMPLE_LONG_X10 + 9) / 10;
	localparam logic [4:0] SAMPLE_SHORT_LAST = 5'(SAMPLE_SHORT_CYC - 1);
	localparam logic [4:0] SAMPLE_LONG_LAST  = 5'(SAMPLE_LONG_CYC - 1);
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SAMPLE  = 2'b01,
		ST_CONVERT = 2'b10,
		ST_FINISH  = 2'b11
	} conv_state_e;
endpackage

// file: hw/conv_clk_if.sv
// interface: conversion clock settings and tick between control and divider
`timescale 1ns/1ps
interface conv_clk_if;
	logic [1:0] source;
	logic [1:0] divide;
	logic       alt_edge;
	logic       async_edge;
	logic       restart;
	logic       tick;
	modport ctrl (output source, output divide, output alt_edge, output async_edge, output restart, input tick);
	modport div  (input source, input divide, input alt_edge, input async_edge, input restart, output tick);
endinterface

// file: hw/pin_sync.sv
// three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module pin_sync (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic pin_i,
	output logic      rise_o
);
	logic [2:0] sync_q, sync_d;
	logic       level_q, level_d;
	logic       rise_q, rise_d;

	always_comb begin
		sync_d  = {sync_q[1:0], pin_i};
		level_d = level_q;
		if (sync_q[1] == sync_q[2]) begin
			level_d = sync_q[2];
		end
		rise_d = level_d & ~level_q;
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			sync_q  <= 3'h0;
			level_q <= 1'b0;
			rise_q  <= 1'b0;
		end else begin
			sync_q  <= sync_d;
			level_q <= level_d;
			rise_q  <= rise_d;
		end
	end

	assign rise_o = rise_q;
endmodule

// file: hw/clock_divider.sv
// conversion clock divider: source select and power-of-two divide, latched at restart
`timescale 1ns/1ps
module clock_divider (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	conv_clk_if.div   clk_if
);
	logic [1:0] src_q, src_d;
	logic [1:0] div_q, div_d;
	logic [2:0] cnt_q, cnt_d;
	logic       half_q, half_d;
	logic       tick_q, tick_d;
	logic       src_tick;

	always_comb begin
		src_d    = src_q;
		div_d    = div_q;
		cnt_d    = cnt_q;
		half_d   = ~half_q;
		tick_d   = 1'b0;
		src_tick = 1'b0;
		unique case (src_q)
			adc_ctrl_pkg::CLK_BUS:      src_tick = 1'b1; // RULE6
			adc_ctrl_pkg::CLK_BUS_HALF: src_tick = half_q;
			adc_ctrl_pkg::CLK_ALT:      src_tick = clk_if.alt_edge;
			adc_ctrl_pkg::CLK_ASYNC:    src_tick = clk_if.async_edge;
		endcase
		if (clk_if.restart) begin
			src_d = clk_if.source; // RULE20
			div_d = clk_if.divide; // RULE20
			cnt_d = 3'h0;
		end else if (src_tick) begin
			if (cnt_q == ((3'h1 << div_q) - 3'h1)) begin // RULE3
				cnt_d  = 3'h0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			src_q  <= adc_ctrl_pkg::CLK_BUS;
			div_q  <= adc_ctrl_pkg::DIV_ONE;
			cnt_q  <= 3'h0;
			half_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			src_q  <= src_d;
			div_q  <= div_d;
			cnt_q  <= cnt_d;
			half_q <= half_d;
			tick_q <= tick_d;
		end
	end

	assign clk_if.tick = tick_q;

	chk_div_bypass: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE3
		(src_q == adc_ctrl_pkg::CLK_BUS && div_q == adc_ctrl_pkg::DIV_ONE && !clk_if.restart) |=> tick_q)
		else $error("undivided bus clock did not tick every cycle");
endmodule

// file: hw/adc_conversion_control.sv
// top: register file, triggering and successive-approximation sequencing of the converter
//Contract
// RULE1: software writes configuration, trigger, then channel
// RULE2: configuration bit 7 selects low power
// RULE3: configuration bits 6:5 divide input clock
// RULE4: configuration bit 4 selects long sampling
// RULE5: configuration bits 3:2 select resolution
// RULE6: configuration bits 1:0 select input clock
// RULE7: trigger bit 7 shows conversion active
// RULE8: trigger bit 6 selects hardware trigger
// RULE9: bits 5:4 enable compare, set direction
// RULE10: trigger bits 3:2 always read zero
// RULE11: software writes zero to trigger bits 1:0
// RULE12: channel bit 7 flags conversion complete
// RULE13: channel bit 6 enables completion interrupt
// RULE14: channel bit 5 selects continuous conversions
// RULE15: channel bits 4:0 select input channel
// RULE16: high read locks result until low read
// RULE17: pin control bits disable digital pins
// RULE18: out-of-range inputs saturate to limits
// RULE19: sampling lasts 3.5 or 23.5 cycles; the code rounds up to 4 or 24 conversion-clock ticks
// RULE20: clock settings take effect at conversion start
// RULE21: channel write clears flag, starts conversion
`timescale 1ns/1ps
module adc_conversion_control (
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [7:0]       rdata_o,
	input  wire logic        hw_trigger_i,
	input  wire logic        alt_clock_i,
	input  wire logic        async_clock_i,
	input  wire logic        comp_i,
	output logic [4:0]       channel_o,
	output logic             sample_o,
	output logic [9:0]       dac_code_o,
	output logic             low_power_o,
	output logic             active_o,
	output logic             irq_o,
	output logic [15:0]      pin_disable_o
);
	conv_clk_if clk_if ();

	logic        hw_rise;
	logic        alt_rise;
	logic        async_rise;
	logic [7:0]  cfg_q, cfg_d;
	logic [7:0]  trg_q, trg_d;
	logic [7:0]  cic_q, cic_d;
	logic        done_q, done_d;
	logic        lock_q, lock_d;
	logic [9:0]  result_q, result_d;
	logic [9:0]  cmpv_q, cmpv_d;
	logic [15:0] pin_q, pin_d;
	logic [7:0]  rdata_q, rdata_d;
	adc_ctrl_pkg::conv_state_e state_q, state_d;
	logic [4:0]  scnt_q, scnt_d;
	logic [3:0]  bit_q, bit_d;
	logic [9:0]  code_q, code_d;
	logic [9:0]  dac_q, dac_d;
	logic        res10_q, res10_d;
	logic        long_q, long_d;
	logic        sample_q, sample_d;
	logic        active_q, active_d;
	logic        irq_q, irq_d;
	logic        wr_chan;
	logic        sw_start;
	logic        hw_start;
	logic        restart;
	logic        busy;
	logic        match;
	logic        xfer_ok;
	logic [9:0]  cmp_ref;
	logic [9:0]  xfer;
	logic [4:0]  stick_q, stick_d;

	pin_sync u_sync_trig (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.pin_i  (hw_trigger_i),
		.rise_o (hw_rise)
	);

	pin_sync u_sync_alt (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.pin_i  (alt_clock_i),
		.rise_o (alt_rise)
	);

	pin_sync u_sync_async (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.pin_i  (async_clock_i),
		.rise_o (async_rise)
	);

	clock_divider u_div (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.clk_if (clk_if)
	);

	assign clk_if.source     = cfg_q[adc_ctrl_pkg::CFG_CLK_LO +: 2];
	assign clk_if.divide     = cfg_q[adc_ctrl_pkg::CFG_DIV_LO +: 2];
	assign clk_if.alt_edge   = alt_rise;
	assign clk_if.async_edge = async_rise;
	assign clk_if.restart    = restart;

	assign busy     = (state_q != adc_ctrl_pkg::ST_IDLE);
	assign wr_chan  = wr_i && (addr_i == adc_ctrl_pkg::OFS_CHAN);
	assign sw_start = wr_chan && !trg_q[adc_ctrl_pkg::TRG_SRC]; // RULE8 RULE21
	assign hw_start = trg_q[adc_ctrl_pkg::TRG_SRC] && hw_rise; // RULE8

	// compare against the value at the active width
	assign cmp_ref = res10_q ? cmpv_q : {2'h0, cmpv_q[7:0]};
	assign match   = trg_q[adc_ctrl_pkg::TRG_CMP_GT] ? (code_q >= cmp_ref) : (code_q < cmp_ref); // RULE9
	assign xfer_ok = (!trg_q[adc_ctrl_pkg::TRG_CMP_EN] || match) && !lock_q; // RULE9 RULE16
	assign xfer    = trg_q[adc_ctrl_pkg::TRG_CMP_EN] ? (code_q - cmp_ref) : code_q;

	always_comb begin
		cfg_d    = cfg_q;
		trg_d    = trg_q;
		cic_d    = cic_q;
		done_d   = done_q;
		lock_d   = lock_q;
		result_d = result_q;
		cmpv_d   = cmpv_q;
		pin_d    = pin_q;
		rdata_d  = 8'h00;
		state_d  = state_q;
		scnt_d   = scnt_q;
		bit_d    = bit_q;
		code_d   = code_q;
		dac_d    = dac_q;
		res10_d  = res10_q;
		long_d   = long_q;
		sample_d = sample_q;
		restart  = 1'b0;
		if (wr_i) begin
			case (addr_i)
				adc_ctrl_pkg::OFS_CHAN: begin
					cic_d  = wdata_i & adc_ctrl_pkg::CIC_WMASK; // RULE14 RULE15
					done_d = 1'b0; // RULE21
				end
				adc_ctrl_pkg::OFS_TRIG:   trg_d = wdata_i & adc_ctrl_pkg::TRG_WMASK; // RULE11
				adc_ctrl_pkg::OFS_CFG:    cfg_d = wdata_i;
				adc_ctrl_pkg::OFS_CMP_HI: cmpv_d[9:8] = wdata_i[1:0];
				adc_ctrl_pkg::OFS_CMP_LO: cmpv_d[7:0] = wdata_i;
				adc_ctrl_pkg::OFS_PIN_A:  pin_d[7:0] = wdata_i; // RULE17
				adc_ctrl_pkg::OFS_PIN_B:  pin_d[15:8] = wdata_i; // RULE17
				default: begin
				end
			endcase
		end
		if (rd_i) begin
			case (addr_i)
				adc_ctrl_pkg::OFS_CHAN: rdata_d = {done_q, cic_q[6:0]}; // RULE12
				adc_ctrl_pkg::OFS_TRIG: rdata_d = {busy, trg_q[6:4], 4'h0}; // RULE7 RULE10
				adc_ctrl_pkg::OFS_RES_HI: begin
					rdata_d = {6'h00, result_q[9:8]};
					lock_d  = 1'b1; // RULE16
				end
				adc_ctrl_pkg::OFS_RES_LO: begin
					rdata_d = result_q[7:0];
					lock_d  = 1'b0; // RULE16
				end
				adc_ctrl_pkg::OFS_CFG:    rdata_d = cfg_q;
				adc_ctrl_pkg::OFS_CMP_HI: rdata_d = {6'h00, cmpv_q[9:8]};
				adc_ctrl_pkg::OFS_CMP_LO: rdata_d = cmpv_q[7:0];
				adc_ctrl_pkg::OFS_PIN_A:  rdata_d = pin_q[7:0];
				adc_ctrl_pkg::OFS_PIN_B:  rdata_d = pin_q[15:8];
				default:                  rdata_d = 8'h00;
			endcase
		end
		unique case (state_q)
			adc_ctrl_pkg::ST_IDLE: begin
			end
			adc_ctrl_pkg::ST_SAMPLE: begin
				if (clk_if.tick) begin
					if (scnt_q == 5'h00) begin // RULE19
						state_d  = adc_ctrl_pkg::ST_CONVERT;
						sample_d = 1'b0;
						bit_d    = res10_q ? adc_ctrl_pkg::MSB_10BIT : adc_ctrl_pkg::MSB_8BIT; // RULE5
						code_d   = 10'h000;
						dac_d    = 10'h001 << bit_d;
					end else begin
						scnt_d = scnt_q - 5'h01;
					end
				end
			end
			adc_ctrl_pkg::ST_CONVERT: begin
				if (clk_if.tick) begin
					// comparator high keeps the trial bit, so a full-scale input gives all ones
					code_d = code_q | (comp_i ? (10'h001 << bit_q) : 10'h000); // RULE18
					if (bit_q == 4'h0) begin
						state_d = adc_ctrl_pkg::ST_FINISH;
					end else begin
						bit_d = bit_q - 4'h1;
						dac_d = code_d | (10'h001 << bit_d);
					end
				end
			end
			adc_ctrl_pkg::ST_FINISH: begin
				if (xfer_ok) begin
					result_d = xfer;
					done_d   = 1'b1; // RULE12
				end
				if (cic_q[adc_ctrl_pkg::CIC_CONT]) begin // RULE14
					restart = 1'b1;
				end else begin
					state_d = adc_ctrl_pkg::ST_IDLE;
				end
			end
		endcase
		if (sw_start || hw_start) begin
			restart = 1'b1;
		end
		if (restart) begin
			state_d  = adc_ctrl_pkg::ST_SAMPLE;
			sample_d = 1'b1;
			res10_d  = (cfg_q[adc_ctrl_pkg::CFG_MODE_LO +: 2] == adc_ctrl_pkg::MODE_10BIT); // RULE5
			long_d   = cfg_q[adc_ctrl_pkg::CFG_LSMP]; // RULE4
			scnt_d   = long_d ? adc_ctrl_pkg::SAMPLE_LONG_LAST : adc_ctrl_pkg::SAMPLE_SHORT_LAST; // RULE19
			dac_d    = 10'h000;
		end
		active_d = (state_d != adc_ctrl_pkg::ST_IDLE); // RULE7
		irq_d    = done_d && cic_d[adc_ctrl_pkg::CIC_IEN]; // RULE13
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			cfg_q    <= adc_ctrl_pkg::RST_BYTE;
			trg_q    <= adc_ctrl_pkg::RST_BYTE;
			cic_q    <= adc_ctrl_pkg::RST_BYTE;
			done_q   <= 1'b0;
			lock_q   <= 1'b0;
			result_q <= adc_ctrl_pkg::RST_WORD;
			cmpv_q   <= adc_ctrl_pkg::RST_WORD;
			pin_q    <= 16'h0000;
			rdata_q  <= adc_ctrl_pkg::RST_BYTE;
			state_q  <= adc_ctrl_pkg::ST_IDLE;
			scnt_q   <= 5'h00;
			bit_q    <= 4'h0;
			code_q   <= adc_ctrl_pkg::RST_WORD;
			dac_q    <= adc_ctrl_pkg::RST_WORD;
			res10_q  <= 1'b0;
			long_q   <= 1'b0;
			sample_q <= 1'b0;
			active_q <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			cfg_q    <= cfg_d;
			trg_q    <= trg_d;
			cic_q    <= cic_d;
			done_q   <= done_d;
			lock_q   <= lock_d;
			result_q <= result_d;
			cmpv_q   <= cmpv_d;
			pin_q    <= pin_d;
			rdata_q  <= rdata_d;
			state_q  <= state_d;
			scnt_q   <= scnt_d;
			bit_q    <= bit_d;
			code_q   <= code_d;
			dac_q    <= dac_d;
			res10_q  <= res10_d;
			long_q   <= long_d;
			sample_q <= sample_d;
			active_q <= active_d;
			irq_q    <= irq_d;
		end
	end

	assign rdata_o       = rdata_q;
	assign channel_o     = cic_q[4:0]; // RULE15
	assign sample_o      = sample_q;
	assign dac_code_o    = dac_q;
	assign low_power_o   = cfg_q[adc_ctrl_pkg::CFG_LOWPWR]; // RULE2
	assign active_o      = active_q;
	assign irq_o         = irq_q;
	assign pin_disable_o = pin_q; // RULE17

	// helper: conversion-clock ticks seen in the sampling phase
	always_comb begin
		stick_d = stick_q;
		if (restart) begin
			stick_d = 5'h00;
		end else if (state_q == adc_ctrl_pkg::ST_SAMPLE && clk_if.tick) begin
			stick_d = stick_q + 5'h01;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			stick_q <= 5'h00;
		end else begin
			stick_q <= stick_d;
		end
	end

	chk_sample_length: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE19
		(state_q == adc_ctrl_pkg::ST_SAMPLE && state_d == adc_ctrl_pkg::ST_CONVERT)
		|-> stick_q == (long_q ? adc_ctrl_pkg::SAMPLE_LONG_LAST : adc_ctrl_pkg::SAMPLE_SHORT_LAST))
		else $error("sampling phase length wrong");

	chk_trig_reserved: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE10
		(rd_i && addr_i == adc_ctrl_pkg::OFS_TRIG) |=> rdata_o[3:0] == 4'h0)
		else $error("unimplemented trigger bits read nonzero");

	chk_active_flag: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE7
		(rd_i && addr_i == adc_ctrl_pkg::OFS_TRIG) |=> rdata_o[7] == $past(busy))
		else $error("active flag does not match conversion state");

	chk_done_sets: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE12
		(state_q == adc_ctrl_pkg::ST_FINISH && xfer_ok) |=> done_q && result_q == $past(xfer))
		else $error("completion did not set flag and result");

	chk_irq_follow: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE13
		irq_o == (done_q && cic_q[adc_ctrl_pkg::CIC_IEN]))
		else $error("interrupt request does not follow flag and enable");

	chk_lock_holds: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE16
		(lock_q && !(rd_i && addr_i == adc_ctrl_pkg::OFS_RES_LO)) |=> $stable(result_q))
		else $error("locked result was overwritten");

	chk_single_shot: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE14
		(state_q == adc_ctrl_pkg::ST_FINISH && !cic_q[adc_ctrl_pkg::CIC_CONT] && !sw_start && !hw_start)
		|=> state_q == adc_ctrl_pkg::ST_IDLE ##1 !sample_o)
		else $error("single conversion did not stop");

	chk_sw_start: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE21
		sw_start |=> state_q == adc_ctrl_pkg::ST_SAMPLE && sample_o)
		else $error("channel write did not start a conversion");

	chk_hw_ignore: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE8
		(wr_chan && trg_q[adc_ctrl_pkg::TRG_SRC] && !busy && !hw_rise) |=> !busy)
		else $error("channel write started a conversion in hardware trigger mode");
endmodule

// file: test/analog_core_model.sv
// behavioural analog core: one driven input channel and the comparator
`timescale 1ns/1ps
module analog_core_model #(
	parameter int LEVEL_CH = 3
) (
	input  wire logic        mclk_i,
	input  wire logic [4:0]  channel_i,
	input  wire logic        sample_i,
	input  wire logic [9:0]  dac_code_i,
	input  wire logic        ten_bit_i,
	input  wire logic [10:0] level_i,
	output logic             comp_o
);
	logic        junk_q = 1'b0;
	logic [10:0] volt;
	logic [10:0] trial;

	// comparator is meaningless while sampling, so it wobbles
	always @(posedge mclk_i) begin
		junk_q <= ~junk_q;
	end
	// other channels sit at the low reference
	assign volt   = (channel_i == 5'(LEVEL_CH)) ? level_i : 11'h000;
	// levels past full scale compare high on every trial
	assign trial  = ten_bit_i ? {1'b0, dac_code_i} : {1'b0, dac_code_i[7:0], 2'h0};
	// pin control bits are not looked at
	assign comp_o = sample_i ? junk_q : (volt >= trial);
endmodule

// file: test/adc_conversion_control_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
	logic        mclk_i        = 1'b0;
	logic        nrst_i        = 1'b0;
	logic [3:0]  addr_i        = 4'h0;
	logic [7:0]  wdata_i       = 8'h00;
	logic        wr_i          = 1'b0;
	logic        rd_i          = 1'b0;
	logic        hw_trigger_i  = 1'b0;
	logic        alt_clock_i   = 1'b0;
	logic        async_clock_i = 1'b0;
	logic        ten_bit       = 1'b1;
	logic [10:0] level         = 11'h000;
	logic [7:0]  rdata_o;
	logic [4:0]  channel_o;
	logic        sample_o;
	logic        comp_i;
	logic [9:0]  dac_code_o;
	logic        low_power_o;
	logic        active_o;
	logic        irq_o;
	logic [15:0] pin_disable_o;
	logic [7:0]  rv;
	int          slen;
	int          num_errors    = 0;
	int          compares      = 0;

	always #10 mclk_i = ~mclk_i;
	always #37 alt_clock_i = ~alt_clock_i;
	always #53 async_clock_i = ~async_clock_i;

	adc_conversion_control adc_conversion_control_inst (
		.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .hw_trigger_i(hw_trigger_i), .alt_clock_i(alt_clock_i), .async_clock_i(async_clock_i),
		.comp_i(comp_i), .channel_o(channel_o), .sample_o(sample_o), .dac_code_o(dac_code_o),
		.low_power_o(low_power_o), .active_o(active_o), .irq_o(irq_o), .pin_disable_o(pin_disable_o)
	);
	analog_core_model analog_core_model_inst (
		.mclk_i(mclk_i), .channel_i(channel_o), .sample_i(sample_o), .dac_code_i(dac_code_o),
		.ten_bit_i(ten_bit), .level_i(level), .comp_o(comp_i)
	);

	task automatic finish_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		check_val({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		rd(a, rv);
		check_val({8'h00, rv}, {8'h00, e});
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (active_o !== 1'b0 && n < 400) begin
			@(posedge mclk_i);
			#1 n++;
		end
		if (n >= 400) begin
			num_errors++;
			$display("ERROR %0t: conversion never ended", $time);
			finish_test();
		end
	endtask
	// start by channel write, measure sampling, look inside, wait for the end
	task automatic convert(input logic [7:0] ch);
		int n;
		n    = 0;
		slen = 0;
		wr(adc_ctrl_pkg::OFS_CHAN, ch);
		#1;
		while (sample_o !== 1'b1 && n < 20) begin
			@(posedge mclk_i);
			#1 n++;
		end
		while (sample_o === 1'b1 && slen < 400) begin
			@(posedge mclk_i);
			#1 slen++;
		end
		if (n >= 20 || slen >= 400) begin
			num_errors++;
			$display("ERROR %0t: sampling phase timed out", $time);
			finish_test();
		end
		rd_chk(adc_ctrl_pkg::OFS_CHAN, {1'b0, ch[6:0]});
		rd(adc_ctrl_pkg::OFS_TRIG, rv);
		check_bit(rv[7], 1'b1);
		wait_idle();
	endtask
	task automatic res_chk(input logic [15:0] e);
		rd_chk(adc_ctrl_pkg::OFS_RES_HI, e[15:8]);
		rd_chk(adc_ctrl_pkg::OFS_RES_LO, e[7:0]);
	endtask
	task automatic sat_case(input logic [7:0] cfg, input logic tb, input logic [10:0] lv, input logic [15:0] e);
		wr(adc_ctrl_pkg::OFS_CFG, cfg);
		ten_bit <= tb;
		level   <= lv;
		convert(8'h03);
		// sample_o also covers the divider restart cycle before the first tick
		check_val(16'(slen), 16'(adc_ctrl_pkg::SAMPLE_SHORT_CYC + 1));
		res_chk(e);
	endtask
	task automatic div_case(input logic [7:0] cfg, input int lo, input int hi);
		wr(adc_ctrl_pkg::OFS_CFG, cfg);
		convert(8'h03);
		check_bit(slen >= lo && slen <= hi, 1'b1);
	endtask

	task automatic t_reset();
		for (int a = 0; a < 9; a++) begin
			rd_chk(4'(a), 8'h00);
		end
		rd_chk(4'hF, 8'h00);
		check_val(pin_disable_o, 16'h0000);
		check_bit(active_o | irq_o | sample_o | low_power_o, 1'b0);
	endtask
	task automatic t_config();
		wr(adc_ctrl_pkg::OFS_CFG, 8'h98);
		wr(adc_ctrl_pkg::OFS_TRIG, 8'hFC);
		rd_chk(adc_ctrl_pkg::OFS_TRIG, 8'h70);
		wr(adc_ctrl_pkg::OFS_TRIG, 8'h00);
		rd_chk(adc_ctrl_pkg::OFS_CFG, 8'h98);
		check_bit(low_power_o, 1'b1);
		wr(adc_ctrl_pkg::OFS_PIN_A, 8'h02);
		wr(adc_ctrl_pkg::OFS_PIN_B, 8'h80);
		#1 check_val(pin_disable_o, 16'h8002);
	endtask
	task automatic t_single();
		level <= 11'h3FF;
		convert(8'h41);
		check_val(16'(slen), 16'(adc_ctrl_pkg::SAMPLE_LONG_CYC + 1));
		check_val({11'h000, channel_o}, 16'h0001);
		check_bit(irq_o, 1'b1);
		rd_chk(adc_ctrl_pkg::OFS_CHAN, 8'hC1);
		rd_chk(adc_ctrl_pkg::OFS_TRIG, 8'h00);
		res_chk(16'h0000);
	endtask
	task automatic t_lock();
		wr(adc_ctrl_pkg::OFS_CFG, 8'h08);
		level <= 11'h155;
		convert(8'h03);
		rd_chk(adc_ctrl_pkg::OFS_RES_HI, 8'h01);
		level <= 11'h2AA;
		convert(8'h03);
		rd_chk(adc_ctrl_pkg::OFS_CHAN, 8'h03);
		rd_chk(adc_ctrl_pkg::OFS_RES_LO, 8'h55);
		convert(8'h03);
		res_chk(16'h02AA);
	endtask
	task automatic t_cmp();
		wr(adc_ctrl_pkg::OFS_CMP_HI, 8'h01);
		wr(adc_ctrl_pkg::OFS_CMP_LO, 8'h00);
		wr(adc_ctrl_pkg::OFS_TRIG, 8'h30);
		level <= 11'h180;
		convert(8'h03);
		rd_chk(adc_ctrl_pkg::OFS_CHAN, 8'h83);
		res_chk(16'h0080);
		wr(adc_ctrl_pkg::OFS_TRIG, 8'h20);
		convert(8'h03);
		rd_chk(adc_ctrl_pkg::OFS_CHAN, 8'h03);
		level <= 11'h0C0;
		convert(8'h03);
		rd_chk(adc_ctrl_pkg::OFS_CHAN, 8'h83);
		res_chk(16'h03C0);
		wr(adc_ctrl_pkg::OFS_TRIG, 8'h00);
	endtask
	task automatic t_cont();
		int n;
		n = 0;
		wr(adc_ctrl_pkg::OFS_CFG, 8'h08);
		wr(adc_ctrl_pkg::OFS_CHAN, 8'h23);
		rv = 8'h00;
		while (rv[7] !== 1'b1 && n < 60) begin
			rd(adc_ctrl_pkg::OFS_CHAN, rv);
			n++;
		end
		check_bit(rv[7], 1'b1);
		if (n >= 60) begin
			finish_test();
		end
		repeat (2) @(posedge mclk_i);
		#1 check_bit(active_o, 1'b1);
		wr(adc_ctrl_pkg::OFS_CHAN, 8'h03);
		wait_idle();
		repeat (40) @(posedge mclk_i);
		#1 check_bit(active_o, 1'b0);
	endtask
	task automatic t_hw();
		wr(adc_ctrl_pkg::OFS_TRIG, 8'h40);
		wr(adc_ctrl_pkg::OFS_CHAN, 8'h03);
		repeat (20) @(posedge mclk_i);
		#1 check_bit(active_o, 1'b0);
		@(posedge mclk_i);
		hw_trigger_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		hw_trigger_i <= 1'b0;
		#1 check_bit(active_o, 1'b1);
		wait_idle();
		rd_chk(adc_ctrl_pkg::OFS_CHAN, 8'h83);
		wr(adc_ctrl_pkg::OFS_TRIG, 8'h00);
	endtask

	initial begin
		repeat (12) @(posedge mclk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_config();
		t_single();
		sat_case(8'h00, 1'b0, 11'h7FF, 16'h00FF);
		sat_case(8'h04, 1'b0, 11'h000, 16'h0000);
		sat_case(8'h08, 1'b1, 11'h7FF, 16'h03FF);
		t_lock();
		t_cmp();
		div_case(8'h28, 7, 9);
		div_case(8'h48, 17, 17);
		div_case(8'h68, 33, 33);
		div_case(8'h09, 7, 9);
		div_case(8'h0A, 10, 18);
		div_case(8'h0B, 14, 24);
		t_cont();
		t_hw();
		finish_test();
	end
endmodule
